// *** hw/acbs_lane_cell.sv ***
`timescale 1ns/100ps
module acbs_lane_cell (
  input  wire logic                 tck,
  input  wire logic                 tckRst,
  input  wire logic                 captureEn,
  input  wire logic                 shiftEn,
  input  wire logic                 updateEn,
  input  wire logic                 scanIn,
  input  wire logic                 captureVal,
  input  wire acbs_pkg::acbs_drv_t  drv,
  output logic                      scanOut,
  output logic                      driveOut
);
  import acbs_pkg::*;

  logic shiftBit;
  logic updBit;
  logic driveBit;
  logic next_shiftBit;
  logic next_updBit;
  logic next_driveBit;

  always_comb begin
    next_shiftBit = shiftBit;
    if (captureEn) begin
      next_shiftBit = captureVal;
    end else if (shiftEn) begin
      next_shiftBit = scanIn;
    end
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      shiftBit <= RST_BIT;
    end else begin
      shiftBit <= next_shiftBit;
    end
  end

  always_comb begin
    next_updBit   = updateEn ? shiftBit : updBit;
    next_driveBit = driveBit;
    unique case (drv)
      DRV_HOLD:   next_driveBit = driveBit;
      DRV_DATA:   next_driveBit = next_updBit;
      DRV_INVERT: next_driveBit = ~updBit;
      DRV_TOGGLE: next_driveBit = ~driveBit;
    endcase
  end

  // the driver only moves on falling tck edges
  always_ff @(negedge tck) begin
    if (tckRst) begin
      updBit   <= RST_BIT;
      driveBit <= RST_BIT;
    end else begin
      updBit   <= next_updBit;
      driveBit <= next_driveBit;
    end
  end

  assign scanOut  = shiftBit;
  assign driveOut = driveBit;

endmodule

// *** hw/acbs_pkg.sv ***
package acbs_pkg;

  // transceiver lanes covered by the ac test cells
  localparam int LANES = 4;
  localparam int IR_W  = 10;

  // instruction codes
  localparam logic [9:0] IR_PULSE   = 10'h08F;
  localparam logic [9:0] IR_TRAIN   = 10'h04F;
  localparam logic [9:0] IR_EXTEST  = 10'h000;
  localparam logic [9:0] IR_BYPASS  = 10'h3FF;
  // value loaded into the instruction shifter in capture-ir
  localparam logic [9:0] IR_CAPTURE = 10'h001;

  // reset values
  localparam logic       RST_BIT    = 1'b0;
  localparam logic [3:0] RST_LANES  = 4'h0;

  // synchroniser depths
  localparam int PIN_STAGES = 3;
  localparam int CDC_STAGES = 2;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } acbs_tap_t;

  typedef enum logic [1:0] {
    MODE_BYPASS, MODE_EXTEST, MODE_PULSE, MODE_TRAIN
  } acbs_mode_t;

  typedef enum logic [1:0] {
    DRV_HOLD, DRV_DATA, DRV_INVERT, DRV_TOGGLE
  } acbs_drv_t;

endpackage

// *** hw/acbs_sync.sv ***
`timescale 1ns/100ps
module acbs_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import acbs_pkg::*;

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] mid;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      mid  <= '0;
    end else begin
      meta <= d;
      mid  <= meta;
    end
  end

  generate
    if (STAGES == PIN_STAGES) begin : g_filter
      logic [WIDTH-1:0] last;
      logic [WIDTH-1:0] held;
      logic [WIDTH-1:0] next_held;
      // a pin change counts only once the second and third stage agree
      always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
          next_held[i] = (mid[i] == last[i]) ? last[i] : held[i];
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          last <= '0;
          held <= '0;
        end else begin
          last <= mid;
          held <= next_held;
        end
      end
      assign q = held;
    end else begin : g_plain
      assign q = mid;
    end
  endgenerate

endmodule

// *** hw/acbs_top.sv ***
`timescale 1ns/100ps
// Functional notes
// R01: code 0010001111 selects the single-pulse ac test instruction.
// R02: single pulse gives three output transitions per update/idle/leave cycle.
// R03: falling tck in update-ir or update-dr drives true cell data.
// R04: first falling tck after entering run-test/idle drives inverted data.
// R05: falling tck after leaving run-test/idle drives true data again.
// R06: tester uses plain extest for dc-coupled transceiver lanes.
// R07: tester uses single-pulse instruction for ac-coupled transceiver lanes.
// R08: lane boundary testing, ac or dc, only after configuration.
// R09: code 0001001111 selects the pulse-train ac test instruction.
// R10: pulse train equals single pulse except behaviour inside run-test/idle.
// R11: pulse train inverts output on every falling tck while in idle.
// R12: ac codes do nothing before configuration.
// R13: tester holds configuration restart low while testing before configuration.
// R14: tester drives tck, tms, tdi; the device drives tdo.
// R15: ac instructions make receivers detect transitions, not static levels.
// R16: standard tap state machine with a ten-bit instruction register.
module acbs_top (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       tck,
  input  wire logic                       tms,
  input  wire logic                       tdi,
  output logic                            tdo,
  output logic                            tdoOe,
  input  wire logic                       configDone,
  input  wire logic                       configRestartN,
  input  wire logic [acbs_pkg::LANES-1:0] laneRx,
  output logic      [acbs_pkg::LANES-1:0] laneTestDrive,
  output logic                            laneTestEn,
  output logic                            acTestActive
);
  import acbs_pkg::*;

  // ---------------- system clock domain ----------------
  logic             restartNSync;
  logic             configured;
  logic             next_configured;

  acbs_sync #(
    .WIDTH  (1),
    .STAGES (PIN_STAGES)
  ) u_restart_sync (
    .clk (clock),
    .rst (rst),
    .d   (configRestartN),
    .q   (restartNSync)
  );

  // a low restart pin drops the device back to pre-configuration
  always_comb begin
    next_configured = configDone & restartNSync;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      configured <= RST_BIT;
    end else begin
      configured <= next_configured;
    end
  end

  // ---------------- reset into the tck domain ----------------
  // tck may stand still, so the tap leaves reset only once tck has risen twice after rst drops
  logic rstMeta;
  logic tckRst;
  logic next_rstMeta;
  logic next_tckRst;

  // reset is sampled twice on tck, so its release never lands mid-cycle on the tap
  always_comb begin
    next_rstMeta = rst;
    next_tckRst  = rstMeta;
  end

  always_ff @(posedge tck) begin
    rstMeta <= next_rstMeta;
    tckRst  <= next_tckRst;
  end

  // ---------------- tck domain ----------------
  logic                   configuredTck;
  acbs_tap_t              tapState;
  acbs_tap_t              next_tapState;
  logic [IR_W-1:0]        irShift;
  logic [IR_W-1:0]        next_irShift;
  logic                   bypassBit;
  logic                   next_bypassBit;
  logic [LANES-1:0]       rxLevel;
  logic [LANES-1:0]       rxPrev;
  logic [LANES-1:0]       rxEdge;
  logic [LANES-1:0]       next_rxEdge;
  acbs_mode_t             mode;
  acbs_mode_t             next_mode;
  logic                   idleSeen;
  logic                   next_idleSeen;
  acbs_drv_t              drv;
  logic                   acMode;
  logic                   laneSel;
  logic                   next_tdo;
  logic                   next_tdoOe;
  logic                   next_laneTestEn;
  logic                   acActiveTck;
  logic                   next_acActiveTck;
  logic [LANES-1:0]       captureVal;
  logic [LANES:0]         chain;
  logic [LANES-1:0]       cellDrive;
  logic                   cellCapture;
  logic                   cellShift;
  logic                   cellUpdate;

  acbs_sync #(
    .WIDTH  (1),
    .STAGES (CDC_STAGES)
  ) u_config_sync (
    .clk (tck),
    .rst (tckRst),
    .d   (configured),
    .q   (configuredTck)
  );

  acbs_sync #(
    .WIDTH  (LANES),
    .STAGES (PIN_STAGES)
  ) u_rx_sync (
    .clk (tck),
    .rst (tckRst),
    .d   (laneRx),
    .q   (rxLevel)
  );

  // R14: tms steers the tap
  // R16: standard tap sequence
  always_comb begin
    next_tapState = tapState;
    unique case (tapState)
      TAP_RESET:    next_tapState = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     next_tapState = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   next_tapState = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   next_tapState = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tapState = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tapState = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tapState = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tapState = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   next_tapState = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   next_tapState = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   next_tapState = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tapState = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tapState = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tapState = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tapState = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   next_tapState = tms ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  end

  // R16: ten-bit instruction shifter, lsb out first
  always_comb begin
    next_irShift = irShift;
    if (tapState == TAP_CAP_IR) begin
      next_irShift = IR_CAPTURE;
    end else if (tapState == TAP_SHIFT_IR) begin
      next_irShift = {tdi, irShift[IR_W-1:1]};
    end
  end

  always_comb begin
    next_bypassBit = bypassBit;
    if (tapState == TAP_CAP_DR) begin
      next_bypassBit = 1'b0;
    end else if (tapState == TAP_SHIFT_DR) begin
      next_bypassBit = tdi;
    end
  end

  // R15: in ac modes a receiver cell reports a seen transition
  always_comb begin
    next_rxEdge = rxEdge;
    if (tapState == TAP_UPD_DR) begin
      next_rxEdge = RST_LANES;
    end
    // a transition in the clearing cycle still sets the flag
    next_rxEdge = next_rxEdge | (rxLevel ^ rxPrev);
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      tapState  <= TAP_RESET;
      irShift   <= IR_CAPTURE;
      bypassBit <= RST_BIT;
      rxPrev    <= RST_LANES;
      rxEdge    <= RST_LANES;
    end else begin
      tapState  <= next_tapState;
      irShift   <= next_irShift;
      bypassBit <= next_bypassBit;
      rxPrev    <= rxLevel;
      rxEdge    <= next_rxEdge;
    end
  end

  // instruction decode, taken on the falling edge in update-ir
  always_comb begin
    next_mode = mode;
    if (tapState == TAP_RESET) begin
      next_mode = MODE_BYPASS;
    end else if (tapState == TAP_UPD_IR) begin
      unique case (irShift)
        // R01: single pulse code
        IR_PULSE:  next_mode = MODE_PULSE;
        // R09: pulse train code
        IR_TRAIN:  next_mode = MODE_TRAIN;
        IR_EXTEST: next_mode = MODE_EXTEST;
        default:   next_mode = MODE_BYPASS;
      endcase
    end
    // R08: no lane testing before configuration
    // R12: ac codes inert until configured
    if (!configuredTck) begin
      next_mode = MODE_BYPASS;
    end
  end

  // cells only move while a lane instruction owns the data register
  always_comb begin
    acMode      = (mode == MODE_PULSE) || (mode == MODE_TRAIN);
    laneSel     = (mode != MODE_BYPASS);
    cellCapture = laneSel && (tapState == TAP_CAP_DR);
    cellShift   = laneSel && (tapState == TAP_SHIFT_DR);
    cellUpdate  = laneSel && (tapState == TAP_UPD_DR);
  end

  // driver control for each falling tck edge
  always_comb begin
    // R03: update states drive true data
    // R05: leaving idle restores true data
    drv           = DRV_DATA;
    next_idleSeen = (tapState == TAP_IDLE);
    if (acMode && (tapState == TAP_IDLE)) begin
      if (!idleSeen) begin
        // R04: first falling edge in idle inverts
        drv = DRV_INVERT;
      end else if (mode == MODE_TRAIN) begin
        // R11: train keeps toggling in idle
        drv = DRV_TOGGLE;
      end else begin
        // R02: pulse holds, so only three transitions
        // R10: only idle differs between pulse and train
        drv = DRV_HOLD;
      end
    end
  end

  // R15: capture transitions rather than levels in ac modes
  assign captureVal = acMode ? rxEdge : rxLevel;
  assign chain[LANES] = tdi;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      acbs_lane_cell u_cell (
        .tck        (tck),
        .tckRst     (tckRst),
        .captureEn  (cellCapture),
        .shiftEn    (cellShift),
        .updateEn   (cellUpdate),
        .scanIn     (chain[g+1]),
        .captureVal (captureVal[g]),
        .drv        (drv),
        .scanOut    (chain[g]),
        .driveOut   (cellDrive[g])
      );
    end
  endgenerate

  assign laneTestDrive = cellDrive;

  // R14: tdo changes on falling tck and floats outside shift
  always_comb begin
    next_tdoOe = (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);
    if (tapState == TAP_SHIFT_IR) begin
      next_tdo = irShift[0];
    end else if (laneSel) begin
      next_tdo = chain[0];
    end else begin
      next_tdo = bypassBit;
    end
  end

  // status follows the decoded mode at the same falling edge as the mode itself
  always_comb begin
    next_laneTestEn  = (next_mode != MODE_BYPASS);
    next_acActiveTck = (next_mode == MODE_PULSE) || (next_mode == MODE_TRAIN);
  end

  always_ff @(negedge tck) begin
    if (tckRst) begin
      mode     <= MODE_BYPASS;
      idleSeen <= RST_BIT;
    end else begin
      mode     <= next_mode;
      idleSeen <= next_idleSeen;
    end
  end

  always_ff @(negedge tck) begin
    if (tckRst) begin
      tdo   <= RST_BIT;
      tdoOe <= RST_BIT;
    end else begin
      tdo   <= next_tdo;
      tdoOe <= next_tdoOe;
    end
  end

  always_ff @(negedge tck) begin
    if (tckRst) begin
      laneTestEn  <= RST_BIT;
      acActiveTck <= RST_BIT;
    end else begin
      laneTestEn  <= next_laneTestEn;
      acActiveTck <= next_acActiveTck;
    end
  end

  // ---------------- status back into the system clock domain ----------------
  acbs_sync #(
    .WIDTH  (1),
    .STAGES (CDC_STAGES)
  ) u_active_sync (
    .clk (clock),
    .rst (rst),
    .d   (acActiveTck),
    .q   (acTestActive)
  );

endmodule

// *** verif/acbs_tester.sv ***
`timescale 1ns/100ps
module acbs_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  logic seen;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tester drives clock
  // tck stays low between calls; tms and tdi move only while it is low
  task automatic step(input logic m, input logic v);
    tms = m;
    tdi = v;
    #32 seen = tdoOe ? tdo : ~tdi;
    tck = 1'b1;
    #32 tck = 1'b0;
  endtask
  // standard scan walk
  // from idle or update to the next update, n bits lsb first
  task automatic scan(input logic ir, input int n, input logic [9:0] v, output logic [9:0] cap);
    cap = 10'h000;
    step(1'b1, ~tdi);
    if (ir) step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i]);
      cap[i] = seen;
    end
    step(1'b1, ~tdi);
  endtask
endmodule

// *** verif/acbs_top_bench.sv ***
`timescale 1ns/100ps
module acbs_top_bench;
  import acbs_pkg::*;
  logic             clock, rst, tck, tms, tdi, tdo, tdoOe, configDone, configRestartN;
  logic             laneTestEn, acTestActive;
  logic [LANES-1:0] laneRx, laneTestDrive, d, prevRx;
  logic [9:0]       cap, code;
  logic [31:0]      seed;
  int               failCount, nCompared, k;

  acbs_top acbs_top_i (
    .clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
    .configDone(configDone), .configRestartN(configRestartN), .laneRx(laneRx),
    .laneTestDrive(laneTestDrive), .laneTestEn(laneTestEn), .acTestActive(acTestActive)
  );
  acbs_tester acbs_tester_i (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [9:0] codeOf(input int i);
    return (i == 0) ? IR_EXTEST : (i == 1) ? IR_PULSE : IR_TRAIN;
  endfunction
  // lane value after n falling edges in idle
  function automatic logic [3:0] idleExp(input logic [9:0] c, input logic [3:0] v, input int n);
    if (c == IR_EXTEST) return v;
    return (c == IR_TRAIN && n % 2 == 0) ? v : ~v;
  endfunction

  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic printVerdict;
    $display("compared %0d failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // the status flag crosses into the system clock, so poll it a bounded while
  task automatic waitAct(input logic v);
    for (int i = 0; i < 20 && acTestActive !== v; i++) @(posedge clock);
    check(10'(acTestActive), 10'(v), "active");
    if (acTestActive !== v) printVerdict();
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    configDone = 1'b0;
    configRestartN = 1'b0;
    laneRx = 4'h0;
    seed = 32'h0000_002F;
    failCount = 0;
    nCompared = 0;
    fork
      repeat (16) @(posedge clock);
      repeat (8) acbs_tester_i.step(1'b1, 1'b0);
    join
    #1;
    check(10'({laneTestEn, laneTestDrive}), 10'h000, "reset");
    @(posedge clock);
    rst <= 1'b0;
    repeat (4) acbs_tester_i.step(1'b1, 1'b0);
    acbs_tester_i.step(1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      acbs_tester_i.scan(1'b1, 10, codeOf(i), cap);
      #1;
      check(cap, IR_CAPTURE, "ir capture");
      check(10'(laneTestEn), 10'h000, "unconfigured");
      acbs_tester_i.step(1'b0, 1'b0);
    end
    acbs_tester_i.scan(1'b0, 1, 10'h001, cap);
    check(cap, 10'h000, "bypass capture");
    acbs_tester_i.step(1'b0, 1'b0);
    @(posedge clock);
    configRestartN <= 1'b1;
    configDone <= 1'b1;
    repeat (16) @(posedge clock);
    repeat (4) acbs_tester_i.step(1'b0, 1'b0);
    for (int n = 0; n < 12; n++) begin
      seed = xs(seed);
      code = codeOf(n % 3);
      d = seed[3:0];
      k = 1 + int'(seed[5:4]);
      @(posedge clock);
      prevRx = laneRx;
      laneRx <= seed[9:6];
      acbs_tester_i.scan(1'b1, 10, code, cap);
      #1;
      check(10'(laneTestEn), 10'h001, "enable");
      waitAct(code != IR_EXTEST);
      acbs_tester_i.scan(1'b0, 4, 10'(d), cap);
      #1;
      check(10'(laneTestDrive), 10'(d), "update");
      check(cap, 10'((code == IR_EXTEST) ? laneRx : (prevRx ^ laneRx)), "capture");
      for (int j = 1; j <= k; j++) begin
        acbs_tester_i.step(1'b0, seed[j]);
        #1;
        check(10'(laneTestDrive), 10'(idleExp(code, d, j)), "idle");
      end
      acbs_tester_i.step(1'b1, 1'b0);
      #1;
      check(10'(laneTestDrive), 10'(d), "leave");
      repeat (2) acbs_tester_i.step(1'b1, 1'b0);
      acbs_tester_i.step(1'b0, 1'b0);
      #1;
      check(10'(laneTestEn), 10'h000, "tap reset");
    end
    acbs_tester_i.scan(1'b1, 10, IR_TRAIN, cap);
    waitAct(1'b1);
    acbs_tester_i.scan(1'b0, 4, 10'(d), cap);
    @(posedge clock);
    configRestartN <= 1'b0;
    repeat (12) acbs_tester_i.step(1'b0, 1'b0);
    #1;
    check(10'(laneTestEn), 10'h000, "dropped");
    waitAct(1'b0);
    printVerdict();
  end
endmodule

// *** verif/acbs_top_chk.sv ***
`timescale 1ns/100ps
module acbs_top_chk (
  input wire logic                       rst,
  input wire logic                       tck,
  input wire logic                       tms,
  input wire logic                       tdi,
  input wire logic                       tdo,
  input wire logic                       tdoOe,
  input wire logic                       configRestartN,
  input wire logic [acbs_pkg::LANES-1:0] laneTestDrive,
  input wire logic                       laneTestEn
);
  import acbs_pkg::*;
  // next tap state for tms low and high, one nibble per state code
  localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
  logic [3:0] st, next_st, dsh, next_dsh, dat, next_dat;
  logic [9:0] sh, next_sh, ir, next_ir;
  logic       ac;

  // shadow tap, so lane checks know where the tester has walked
  always_comb begin
    next_st  = tms ? NXT1[{st, 2'b00} +: 4] : NXT0[{st, 2'b00} +: 4];
    next_sh  = (st == TAP_SHIFT_IR) ? {tdi, sh[9:1]} : sh;
    next_ir  = (st == TAP_UPD_IR) ? sh : (st == TAP_RESET) ? IR_BYPASS : ir;
    next_dsh = (st == TAP_SHIFT_DR) ? {tdi, dsh[3:1]} : dsh;
    next_dat = (st == TAP_UPD_DR && laneTestEn) ? dsh : dat;
    if (rst) begin
      next_st  = TAP_RESET;
      next_ir  = IR_BYPASS;
      next_dat = 4'h0;
    end
  end
  always_ff @(posedge tck) begin
    {st, sh, ir, dsh, dat} <= {next_st, next_sh, next_ir, next_dsh, next_dat};
  end
  assign ac = laneTestEn && (ir == IR_PULSE || ir == IR_TRAIN);

  default clocking cb @(posedge tck); endclocking
  default disable iff (rst);

  property p_upd;
    st == TAP_UPD_DR && laneTestEn |-> laneTestDrive == dsh;
  endproperty
  a_upd: assert property (p_upd)
    else $error("lanes differ from shifted data at update");
  property p_inv;
    ac && st == TAP_IDLE && $past(st) != TAP_IDLE |-> laneTestDrive == ~dat;
  endproperty
  a_inv: assert property (p_inv)
    else $error("lanes not inverted on idle entry");
  property p_hold;
    ac && ir != IR_TRAIN && st == TAP_IDLE && $past(st) == TAP_IDLE |-> $stable(laneTestDrive);
  endproperty
  a_hold: assert property (p_hold)
    else $error("single pulse moved again in idle");
  property p_leave;
    ac && $past(st) == TAP_IDLE && st == TAP_SEL_DR |-> laneTestDrive == dat;
  endproperty
  a_leave: assert property (p_leave)
    else $error("lanes not true after leaving idle");
  property p_tog;
    ac && ir == IR_TRAIN && st == TAP_IDLE && $past(st) == TAP_IDLE
      |-> laneTestDrive == ~$past(laneTestDrive);
  endproperty
  a_tog: assert property (p_tog)
    else $error("train did not toggle in idle");
  property p_oe;
    tdoOe == (st == TAP_SHIFT_DR || st == TAP_SHIFT_IR);
  endproperty
  a_oe: assert property (p_oe)
    else $error("tdo enable outside shift states");
  property p_cap;
    st == TAP_SHIFT_IR && $past(st) == TAP_CAP_IR |-> tdo == IR_CAPTURE[0];
  endproperty
  a_cap: assert property (p_cap)
    else $error("wrong first instruction capture bit");
  property p_cfg;
    (!configRestartN) [*8] |-> ##2 !laneTestEn;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("test drive enabled while unconfigured");
endmodule

bind acbs_top acbs_top_chk acbs_top_chk_i (
  .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
  .configRestartN(configRestartN), .laneTestDrive(laneTestDrive), .laneTestEn(laneTestEn)
);
